// ---- audio_clk_pkg.sv ----
package audio_clk_pkg;

    // Clock rates
    localparam int unsigned SYS_CLK_HZ      = 50_000_000;
    localparam int unsigned OUT_CLK_HZ      = 12_288_000;

    // Loop multipliers for the two reference rates
    localparam logic [11:0] MULT_SLOW       = 12'hc00;
    localparam logic [11:0] MULT_FAST       = 12'h600;

    // Oscillator: 32-bit phase accumulator, output is the top bit
    localparam logic [31:0] NCO_STEP_NOM    = 32'h3eea_209a;
    localparam logic [31:0] NCO_GAIN        = 32'h0000_4000;

    // Lock detection
    localparam logic [11:0] LOCK_TOL        = 12'h002;
    localparam logic [3:0]  LOCK_RUNS       = 4'h4;
    localparam logic [11:0] CYCLE_CNT_MAX   = 12'hfff;

    // Reference loss: no edge for longer than twice the slowest period
    localparam int unsigned REF_LOSS_TIME_US = 500;
    localparam int unsigned REF_LOSS_CYC     =
        REF_LOSS_TIME_US * (SYS_CLK_HZ / 1_000_000);

    // Settling delay from enable to first output edge
    localparam int unsigned SETTLE_TIME_MS   = 50;
    localparam int unsigned SETTLE_OUT_CYC   =
        SETTLE_TIME_MS * (OUT_CLK_HZ / 1000);

    // Values after reset: open pins read high
    localparam logic        PIN_RESET_HIGH   = 1'b1;
    localparam logic        RESET_LOW        = 1'b0;

    typedef enum logic [1:0] {
        GATE_OFF,
        GATE_SETTLE,
        GATE_RUN,
        GATE_FINISH
    } gate_state_t;

    // Output cycles expected per reference period
    function automatic logic [11:0] expected_count(input logic fast);
        expected_count = fast ? MULT_FAST : MULT_SLOW;
    endfunction

endpackage

// ---- ref_link_if.sv ----
`timescale 1ns/100ps
interface ref_link_if;
    logic edge_toggle;
    modport capture (output edge_toggle);
    modport meter   (input  edge_toggle);
endinterface

// ---- ref_capture.sv ----
`timescale 1ns/100ps
module ref_capture (
    // Link side
    input  wire logic link_clk_in,
    input  wire logic rst_n_in,
    input  wire logic reference_in,
    // Toward the measuring logic
    ref_link_if.capture link
);
    import audio_clk_pkg::*;

    logic rst_meta_reg;
    logic rst_sync_reg;
    logic ref_meta_reg;
    logic ref_sync_reg;
    logic ref_last_reg;
    logic toggle_reg;
    wire  ref_rise;

    // Only the rising edge is used, so the high time never matters
    assign ref_rise         = ref_sync_reg & ~ref_last_reg;
    assign link.edge_toggle = toggle_reg;

    always_ff @(posedge link_clk_in) begin
        rst_meta_reg <= rst_n_in;
        rst_sync_reg <= rst_meta_reg;
    end

    always_ff @(posedge link_clk_in) begin
        if (!rst_sync_reg) begin
            ref_meta_reg <= RESET_LOW;
            ref_sync_reg <= RESET_LOW;
            ref_last_reg <= RESET_LOW;
            toggle_reg   <= RESET_LOW;
        end else begin
            ref_meta_reg <= reference_in;
            ref_sync_reg <= ref_meta_reg;
            ref_last_reg <= ref_sync_reg;
            toggle_reg   <= toggle_reg ^ ref_rise;
        end
    end

endmodule

// ---- audio_clock_multiplier_enable.sv ----
`timescale 1ns/100ps
// Overview of operation
// - Either reference rate yields 12.288 MHz on both matched clock outputs.
// - Select low: slow reference times 3072; select high: fast times 1536.
// - Lock uses reference rising edges only, independent of high-pulse width.
// - Enable pin high forces both outputs low whatever else happens.
// - After enable, wait a settling delay before first rising output edge, unless already locked.
// - On disable, finish the running output cycle, then hold outputs low.
// - Enable is asynchronous and is synchronised before gating outputs.
// - Unconnected enable and select read high: disabled, fast rate.
module audio_clock_multiplier_enable #(
    parameter int unsigned REF_LOSS_CYCLES = audio_clk_pkg::REF_LOSS_CYC,
    parameter int unsigned SETTLE_CYCLES   = audio_clk_pkg::SETTLE_OUT_CYC
) (
    // System clock and reset
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    // Host link clock and reference
    input  wire logic link_clk_in,
    input  wire logic reference_in,
    // Control pins
    input  wire logic rate_select_in,
    input  wire logic output_enable_low_in,
    // Clock outputs and status
    output logic      clock_out_first_out,
    output logic      clock_out_second_out,
    output logic      locked_out
);
    import audio_clk_pkg::*;

    localparam int LOSS_W   = $clog2(REF_LOSS_CYCLES + 1);
    localparam int SETTLE_W = $clog2(SETTLE_CYCLES + 1);

    ref_link_if link ();

    ref_capture u_capture (
        .link_clk_in  (link_clk_in),
        .rst_n_in     (rst_n_in),
        .reference_in (reference_in),
        .link         (link.capture)
    );

    // Synchronisers
    logic en_meta_reg;
    logic en_low_sync_reg;
    logic rate_meta_reg;
    logic rate_sync_reg;
    logic tog_meta_reg;
    logic tog_sync_reg;
    logic tog_last_reg;

    // Loop state
    logic [31:0]         step_reg;
    logic [31:0]         step_next;
    logic [31:0]         phase_reg;
    logic                nco_msb_reg;
    logic [11:0]         cyc_cnt_reg;
    logic [3:0]          good_runs_reg;
    logic [3:0]          good_runs_next;
    logic                locked_reg;
    logic                rate_last_reg;
    logic [LOSS_W-1:0]   loss_cnt_reg;

    // Output gate
    gate_state_t         state_reg;
    gate_state_t         state_next;
    logic [SETTLE_W-1:0] settle_cnt_reg;
    logic                out_first_reg;
    logic                out_second_reg;

    wire [31:0] phase_sum  = phase_reg + step_reg;
    wire        nco_rise   = phase_sum[31] & ~nco_msb_reg;
    wire        ref_tick   = tog_sync_reg ^ tog_last_reg;
    wire        enabled    = ~en_low_sync_reg;
    wire [11:0] target     = expected_count(rate_sync_reg);
    wire        too_slow   = cyc_cnt_reg < (target - LOCK_TOL);
    wire        too_fast   = cyc_cnt_reg > (target + LOCK_TOL);
    wire        in_window  = ~too_slow & ~too_fast;
    wire        rate_flip  = rate_sync_reg ^ rate_last_reg;
    wire        ref_lost   = loss_cnt_reg == LOSS_W'(REF_LOSS_CYCLES);
    wire        settle_end = (settle_cnt_reg == SETTLE_W'(SETTLE_CYCLES))
                             | locked_reg;
    wire        pass_clock = (state_reg == GATE_RUN)
                             | (state_reg == GATE_FINISH);

    // Step trimmed once per reference period toward the target count
    assign step_next = !ref_tick ? step_reg :
                       too_slow  ? step_reg + NCO_GAIN :
                       too_fast  ? step_reg - NCO_GAIN : step_reg;
    assign good_runs_next = (!in_window || rate_flip) ? 4'h0 :
                            (good_runs_reg == LOCK_RUNS) ? good_runs_reg :
                            good_runs_reg + 4'h1;

    assign clock_out_first_out  = out_first_reg;
    assign clock_out_second_out = out_second_reg;
    assign locked_out           = locked_reg;

    // Pins idle high after reset, as they do when left open
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            en_meta_reg     <= PIN_RESET_HIGH;
            en_low_sync_reg <= PIN_RESET_HIGH;
            rate_meta_reg   <= PIN_RESET_HIGH;
            rate_sync_reg   <= PIN_RESET_HIGH;
            rate_last_reg   <= PIN_RESET_HIGH;
        end else begin
            en_meta_reg     <= output_enable_low_in;
            en_low_sync_reg <= en_meta_reg;
            rate_meta_reg   <= rate_select_in;
            rate_sync_reg   <= rate_meta_reg;
            rate_last_reg   <= rate_sync_reg;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            tog_meta_reg <= RESET_LOW;
            tog_sync_reg <= RESET_LOW;
            tog_last_reg <= RESET_LOW;
        end else begin
            tog_meta_reg <= link.edge_toggle;
            tog_sync_reg <= tog_meta_reg;
            tog_last_reg <= tog_sync_reg;
        end
    end

    // Oscillator keeps running while outputs are gated, so it is settled
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            phase_reg   <= 32'h0000_0000;
            nco_msb_reg <= RESET_LOW;
            step_reg    <= NCO_STEP_NOM;
        end else begin
            phase_reg   <= phase_sum;
            nco_msb_reg <= phase_sum[31];
            step_reg    <= step_next;
        end
    end

    // Output cycles counted between reference edges
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || ref_tick) begin
            cyc_cnt_reg <= 12'h000;
        end else if (nco_rise && cyc_cnt_reg != CYCLE_CNT_MAX) begin
            cyc_cnt_reg <= cyc_cnt_reg + 12'h001;
        end
    end

    // A missing reference drops lock rather than freezing a stale one
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || ref_tick) begin
            loss_cnt_reg <= '0;
        end else if (!ref_lost) begin
            loss_cnt_reg <= loss_cnt_reg + LOSS_W'(1);
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || ref_lost || rate_flip) begin
            good_runs_reg <= 4'h0;
            locked_reg    <= RESET_LOW;
        end else if (ref_tick) begin
            good_runs_reg <= good_runs_next;
            locked_reg    <= good_runs_next == LOCK_RUNS;
        end
    end

    // Gate opens and closes only while the oscillator phase is low,
    // so no shortened high pulse ever reaches the pins
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            GATE_OFF: begin
                if (enabled) begin
                    state_next = GATE_SETTLE;
                end
            end
            GATE_SETTLE: begin
                if (!enabled) begin
                    state_next = GATE_OFF;
                end else if (settle_end && !nco_msb_reg) begin
                    state_next = GATE_RUN;
                end
            end
            GATE_RUN: begin
                if (!enabled) begin
                    state_next = GATE_FINISH;
                end
            end
            GATE_FINISH: begin
                if (enabled) begin
                    state_next = GATE_RUN;
                end else if (!nco_msb_reg) begin
                    state_next = GATE_OFF;
                end
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_reg <= GATE_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || state_reg != GATE_SETTLE) begin
            settle_cnt_reg <= '0;
        end else if (nco_rise && !settle_end) begin
            settle_cnt_reg <= settle_cnt_reg + SETTLE_W'(1);
        end
    end

    // Both copies from the same term keep them matched
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            out_first_reg  <= RESET_LOW;
            out_second_reg <= RESET_LOW;
        end else begin
            out_first_reg  <= pass_clock & nco_msb_reg;
            out_second_reg <= pass_clock & nco_msb_reg;
        end
    end

endmodule

// ---- audio_clk_chk.sv ----
`timescale 1ns/100ps
module audio_clk_chk #(
    parameter int unsigned SETTLE_CYCLES = 16
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic rate_select_in,
    input wire logic output_enable_low_in,
    input wire logic clock_out_first_out,
    input wire logic clock_out_second_out,
    input wire logic locked_out
);
    logic [15:0] en_cnt;
    logic [2:0]  hi_cnt;
    logic        armed;
    // Armed by reset or after a long quiet spell, so a resumed finish is not judged
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || output_enable_low_in) en_cnt <= 16'h0000;
        else if (en_cnt != 16'hffff) en_cnt <= en_cnt + 16'h0001;
        if (!rst_n_in || !output_enable_low_in || clock_out_first_out)
            hi_cnt <= 3'h0;
        else if (hi_cnt != 3'h7) hi_cnt <= hi_cnt + 3'h1;
        if (!rst_n_in || hi_cnt == 3'h7) armed <= 1'b1;
        else if (clock_out_first_out) armed <= 1'b0;
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_long_off;
        output_enable_low_in [*6] ##0 !clock_out_first_out;
    endsequence
    sequence s_first_rise;
        $rose(clock_out_first_out) && armed && !locked_out;
    endsequence
    a_outs_matched: assert property (
        clock_out_first_out == clock_out_second_out)
        else $error("clock outputs differ");
    a_disabled_low: assert property (
        s_long_off |=> !clock_out_first_out)
        else $error("output rose while disabled");
    a_finish_bound: assert property (
        $rose(output_enable_low_in) |-> ##[1:12] !clock_out_first_out)
        else $error("output not stopped after disable");
    a_no_short_high: assert property (
        $rose(clock_out_first_out) |=> clock_out_first_out)
        else $error("truncated high pulse");
    a_no_short_low: assert property (
        $fell(clock_out_first_out) |=> !clock_out_first_out)
        else $error("truncated low pulse");
    a_settle_delay: assert property (
        s_first_rise |-> en_cnt >= SETTLE_CYCLES * 3)
        else $error("first edge came before settling");
    a_reset_quiet: assert property (
        $rose(rst_n_in) |-> !clock_out_first_out && !locked_out)
        else $error("outputs active after reset");
    a_rate_clears: assert property (
        $changed(rate_select_in) |-> ##[1:8] !locked_out)
        else $error("lock kept over rate change");
endmodule
bind audio_clock_multiplier_enable audio_clk_chk #(
    .SETTLE_CYCLES(SETTLE_CYCLES)
) u_audio_clk_chk (
    .clk_in, .rst_n_in, .rate_select_in, .output_enable_low_in,
    .clock_out_first_out, .clock_out_second_out, .locked_out
);

// ---- ref_host_model.sv ----
`timescale 1ns/100ps
module ref_host_model (
    // Control
    input  wire logic run_in,
    input  wire logic fast_in,
    // Reference pulses
    output logic      reference_out
);
    int  hi;
    bit  wide;
    initial begin
        reference_out = 1'b0;
        forever begin
            // An undriven control at time zero must not start pulses
            if (run_in !== 1'b1) begin
                #1000;
            end else begin
                // Alternate narrow and wide high times to stress lock
                wide = !wide;
                hi = wide ? 60000 : 320;
                reference_out = 1'b1;
                #(hi);
                reference_out = 1'b0;
                #((fast_in ? 125000 : 250000) - hi);
            end
        end
    end
endmodule

// ---- audio_clock_multiplier_enable_tb_top.sv ----
`timescale 1ns/100ps
module audio_clock_multiplier_enable_tb_top;
    import audio_clk_pkg::*;
    localparam int SETTLE = 16;
    localparam int EXP = 5000 * (OUT_CLK_HZ / 1000) / (SYS_CLK_HZ / 1000);
    logic clk_in, link_clk_in, rst_n_in, rate_select_in;
    logic output_enable_low_in, reference_in, ref_run;
    logic clk_a, clk_b, locked;
    int   failures, comparisons, n;

    audio_clock_multiplier_enable #(
        .REF_LOSS_CYCLES(13000),
        .SETTLE_CYCLES  (SETTLE)
    ) u_audio_clock_multiplier_enable (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .link_clk_in(link_clk_in),
        .reference_in(reference_in), .rate_select_in(rate_select_in),
        .output_enable_low_in(output_enable_low_in),
        .clock_out_first_out(clk_a), .clock_out_second_out(clk_b),
        .locked_out(locked)
    );
    ref_host_model u_ref_host_model (
        .run_in(ref_run), .fast_in(rate_select_in),
        .reference_out(reference_in)
    );
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    initial begin
        link_clk_in = 1'b0;
        #7;
        forever #80 link_clk_in = ~link_clk_in;
    end
    task automatic print_verdict;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check_bit(input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: exp %h got %h", $time, exp, got);
        end
    endtask
    task automatic check_range(input int lo, input int hi, input int got);
        comparisons++;
        if (got < lo || got > hi) begin
            failures++;
            $display("mismatch at %0t: exp %h..%h got %h", $time, lo, hi, got);
        end
    endtask
    task automatic count_rises(input int cycles, output int c);
        logic prev;
        c = 0;
        prev = clk_a;
        repeat (cycles) begin
            @(posedge clk_in);
            if (clk_a === 1'b1 && prev === 1'b0) c++;
            // A split between the two copies spoils the count on purpose
            if (clk_b !== clk_a) c = c + 100000;
            prev = clk_a;
        end
    endtask
    task automatic wait_for(input int bound, input bit lock, output int c);
        c = 0;
        while ((lock ? locked : clk_a) !== 1'b1) begin
            @(posedge clk_in);
            c++;
            if (c > bound) begin
                failures++;
                print_verdict();
            end
        end
    endtask
    task automatic t_idle;
        count_rises(300, n);
        check_range(0, 0, n);
        check_bit(1'b0, locked);
        $display("t_idle done");
    endtask
    task automatic t_settle;
        output_enable_low_in <= 1'b0;
        wait_for(2000, 1'b0, n);
        check_range(SETTLE * 4 - 4, 400, n);
        count_rises(5000, n);
        check_range(EXP - 1, EXP + 2, n);
        $display("t_settle done");
    endtask
    task automatic t_disable;
        wait_for(50, 1'b0, n);
        output_enable_low_in <= 1'b1;
        count_rises(12, n);
        check_bit(1'b0, clk_a);
        count_rises(300, n);
        check_range(0, 0, n);
        $display("t_disable done");
    endtask
    task automatic t_lock;
        output_enable_low_in <= 1'b0;
        wait_for(60000, 1'b1, n);
        check_bit(1'b1, locked);
        count_rises(5000, n);
        check_range(EXP - 1, EXP + 2, n);
        $display("t_lock done");
    endtask
    task automatic t_relock;
        output_enable_low_in <= 1'b1;
        count_rises(30, n);
        check_range(0, 2, n);
        // Already locked, so settling ends long before the count would
        output_enable_low_in <= 1'b0;
        wait_for(40, 1'b0, n);
        check_range(4, 14, n);
        $display("t_relock done");
    endtask
    task automatic t_rate;
        rate_select_in <= 1'b0;
        repeat (10) @(posedge clk_in);
        check_bit(1'b0, locked);
        count_rises(5000, n);
        check_range(EXP - 1, EXP + 2, n);
        $display("t_rate done");
    endtask
    initial begin
        failures = 0;
        comparisons = 0;
        rst_n_in = 1'b0;
        rate_select_in = 1'b1;
        output_enable_low_in = 1'b1;
        ref_run = 1'b0;
        // Long enough for the link-side reset resync as well
        repeat (30) @(posedge clk_in);
        rst_n_in <= 1'b1;
        ref_run <= 1'b1;
        t_idle();
        t_settle();
        t_disable();
        t_lock();
        t_relock();
        t_rate();
        print_verdict();
    end
endmodule
